//--- ctt_pkg.sv
// shared constants and types plus the bypassable divider leaf
package ctt_pkg;
   localparam int CLK_PERIOD_NS  = 50;
   // nominal oscillator period that makes 2^34 ticks come to 283 minutes
   localparam int OSC_PERIOD_NS  = 988;
   localparam int OSC_DIV        = (OSC_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   OSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int PRE_W          = 5;
   localparam int CHAIN_W        = 35;
   localparam int CHAIN_STAGES   = 34;
   localparam int LIMIT_LSB      = 31;
   localparam int SW1_SKIP       = 19;
   localparam int SW2_SKIP       = 11;
   localparam int GATE_SKIP      = 5;
   localparam int HOLD_SKIP      = 11;
   localparam int GATE_PERIOD_MS = 1380;
   localparam int HOLDOFF_S      = 177;
   localparam int GATE_TICKS     = int'(longint'(GATE_PERIOD_MS) * 64'd1000000
                                        / OSC_PERIOD_NS);
   localparam int HOLDOFF_TICKS  = int'(longint'(HOLDOFF_S) * 64'd1000000000
                                        / OSC_PERIOD_NS);
   localparam int GATE_W         = 21;
   localparam int HOLD_W         = 28;
   localparam logic [CHAIN_W-1:0] STEP_NORM = 35'h000000001;
   localparam logic [CHAIN_W-1:0] STEP_SW1  = 35'h000080000;
   localparam logic [CHAIN_W-1:0] STEP_SW2  = 35'h000000800;
   localparam logic [2:0]         SEL_OFF   = 3'h0;

   // comparator flags as delivered by the analogue front end
   typedef struct packed {
      logic       batt_low;
      logic       batt_window;
      logic       tsel0_neg;
      logic       temp_bias;
      logic       uvlo;
      logic [2:0] tsel;
   } ctt_flags_t;

   typedef enum logic [1:0] {
      CTT_FAST    = 2'b00,
      CTT_TRICKLE = 2'b01
   } ctt_state_t;
endpackage : ctt_pkg

`timescale 1ns/1ps
module ctt_skip_div #(
   parameter int W        = 21,
   parameter int TC       = 1000,
   parameter int SKIP     = 5,
   parameter bit PERIODIC = 1'b1
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic clr,
   input  wire logic tick,
   input  wire logic bypass,
   output logic      done_r
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] step;
   logic [W:0]   sum;

   assign step = bypass ? W'(1 << SKIP) : W'(1);
   assign sum  = {1'b0, cnt_r} + {1'b0, step};

   always_ff @(posedge clk) begin
      if (!rst_n || clr) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else if (PERIODIC) begin
         done_r <= 1'b0;
         if (tick) begin
            if (sum >= (W+1)'(TC)) begin
               cnt_r  <= '0;
               done_r <= 1'b1;
            end else begin
               cnt_r <= sum[W-1:0];
            end
         end
      end else if (tick && !done_r) begin
         if (sum >= (W+1)'(TC)) begin
            done_r <= 1'b1;
         end else begin
            cnt_r <= sum[W-1:0];
         end
      end
   end

   a_div_restart: assert property (@(posedge clk) disable iff (!rst_n)
      clr |=> cnt_r == '0 && !done_r) else $error("divider not cleared");
   a_div_step: assert property (@(posedge clk) disable iff (!rst_n)
      tick && !clr && !done_r && sum < (W+1)'(TC) |=> cnt_r == $past(sum[W-1:0]))
      else $error("divider step wrong");
endmodule : ctt_skip_div

//--- ctt_charge_timer.sv
// backup charge timer chain with test bypass switches
`timescale 1ns/1ps
// Behaviour
// - 34-stage chain, longest limit 283 minutes
// - switch one skips 19 stages
// - battery low enables switch one
// - test limits expire in milliseconds
// - fast output falls at limit in test
// - low pack still falls back to trickle
// - switch two skips 11 stages
// - switch two needs low and negative bit0
// - switch two expiry 2.07 s to 8.29 s
// - section A speeds gate 32 times
// - section B speeds holdoff 2048 times
// - negative bit0 enables sections A, B
// - gate period 1.38 s to 43 ms
// - holdoff 177 s to 86 ms
// - three pins select seven limits
// - expiry latches trickle until reset pulse
// - window entry resets timer, goes fast
// - undervoltage holds trickle and timer reset
module ctt_charge_timer
   import ctt_pkg::*;
#(
   parameter int GATE_TICKS_P    = ctt_pkg::GATE_TICKS,
   parameter int HOLDOFF_TICKS_P = ctt_pkg::HOLDOFF_TICKS,
   parameter int OSC_DIV_P       = ctt_pkg::OSC_DIV
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire ctt_pkg::ctt_flags_t flags_in,
   output logic                  fast_trickle_output_r,
   output logic                  sense_sample_gate_output,
   output logic                  timer_reset_pulse_r,
   output logic                  holdoff_done
);
   import ctt_pkg::*;

   ctt_flags_t           sync1_r;
   ctt_flags_t           sync2_r;
   ctt_flags_t           prev_r;
   logic [PRE_W-1:0]     pre_r;
   logic                 tick_r;
   logic [CHAIN_W-1:0]   chain_r;
   logic [CHAIN_W-1:0]   step;
   logic                 sw1;
   logic                 sw2;
   logic                 sec_ab;
   logic                 timer_en;
   logic [3:0]           limit_units;
   logic                 expired;
   logic                 tmr_clr;
   logic                 rst_event;
   ctt_state_t           state_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r  <= '0;
      end else begin
         sync1_r <= flags_in;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // oscillator tick prescaler
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pre_r  <= '0;
         tick_r <= 1'b0;
      end else if (pre_r == PRE_W'(OSC_DIV_P - 1)) begin
         pre_r  <= '0;
         tick_r <= 1'b1;
      end else begin
         pre_r  <= pre_r + PRE_W'(1);
         tick_r <= 1'b0;
      end
   end

   assign sw1    = sync2_r.batt_low;
   assign sw2    = sync2_r.batt_low && sync2_r.tsel0_neg;
   // sections A and B on bias alone
   assign sec_ab = sync2_r.tsel0_neg;

   assign step = sw2 ? STEP_SW2 : (sw1 ? STEP_SW1 : STEP_NORM);

   assign timer_en    = !sync2_r.temp_bias && (sync2_r.tsel != SEL_OFF);
   assign limit_units = {1'b0, sync2_r.tsel} + 4'h1;
   assign expired     = timer_en && (chain_r[CHAIN_W-1:LIMIT_LSB] >= limit_units);

   assign rst_event = (sync2_r.batt_window && !prev_r.batt_window)
                   || (sync2_r.batt_low && !prev_r.batt_low)
                   || (!sync2_r.uvlo && prev_r.uvlo);
   assign tmr_clr   = rst_event || sync2_r.uvlo;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timer_reset_pulse_r <= 1'b0;
      end else begin
         timer_reset_pulse_r <= rst_event;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || tmr_clr) begin
         chain_r <= '0;
      end else if (tick_r && !expired) begin
         chain_r <= chain_r + step;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= CTT_TRICKLE;
      end else begin
         case (state_r)
            CTT_FAST: begin
               if (expired && !rst_event) begin
                  state_r <= CTT_TRICKLE;
               end
            end
            CTT_TRICKLE: begin
               if (rst_event && !sync2_r.uvlo) begin
                  state_r <= CTT_FAST;
               end
            end
            default: begin
               state_r <= CTT_TRICKLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fast_trickle_output_r <= 1'b0;
      end else begin
         fast_trickle_output_r <= (state_r == CTT_FAST) && !expired && !sync2_r.uvlo
                                  && (sync2_r.batt_window || sync2_r.batt_low);
      end
   end

   ctt_skip_div #(
      .W        (GATE_W),
      .TC       (GATE_TICKS_P),
      .SKIP     (GATE_SKIP),
      .PERIODIC (1'b1)
   ) u_gate (
      .clk    (clk),
      .rst_n  (rst_n),
      .clr    (sync2_r.uvlo),
      .tick   (tick_r),
      .bypass (sec_ab),
      .done_r (sense_sample_gate_output)
   );

   ctt_skip_div #(
      .W        (HOLD_W),
      .TC       (HOLDOFF_TICKS_P),
      .SKIP     (HOLD_SKIP),
      .PERIODIC (1'b0)
   ) u_hold (
      .clk    (clk),
      .rst_n  (rst_n),
      .clr    (tmr_clr),
      .tick   (tick_r),
      .bypass (sec_ab),
      .done_r (holdoff_done)
   );

   sequence s_expire_seen;
      expired && !rst_event && state_r == CTT_FAST;
   endsequence

   a_chain_clear: assert property (@(posedge clk) disable iff (!rst_n)
      tmr_clr |=> chain_r == '0) else $error("chain not cleared");
   a_sw1_step: assert property (@(posedge clk) disable iff (!rst_n)
      tick_r && sw1 && !sw2 && !expired && !tmr_clr
      |=> chain_r == $past(chain_r) + STEP_SW1) else $error("switch one step");
   a_sw2_step: assert property (@(posedge clk) disable iff (!rst_n)
      tick_r && sw2 && !expired && !tmr_clr
      |=> chain_r == $past(chain_r) + STEP_SW2) else $error("switch two step");
   a_norm_step: assert property (@(posedge clk) disable iff (!rst_n)
      tick_r && !sw1 && !expired && !tmr_clr
      |=> chain_r == $past(chain_r) + STEP_NORM) else $error("normal step");
   a_expire_trickle: assert property (@(posedge clk) disable iff (!rst_n)
      s_expire_seen |=> state_r == CTT_TRICKLE ##1 !fast_trickle_output_r)
      else $error("expiry not latched");
   a_latch_holds: assert property (@(posedge clk) disable iff (!rst_n)
      state_r == CTT_TRICKLE && !rst_event |=> state_r == CTT_TRICKLE)
      else $error("trickle latch lost");
   a_window_fast: assert property (@(posedge clk) disable iff (!rst_n)
      rst_event && !sync2_r.uvlo |=> state_r == CTT_FAST && timer_reset_pulse_r)
      else $error("reset pulse ignored");
   a_uvlo_trickle: assert property (@(posedge clk) disable iff (!rst_n)
      sync2_r.uvlo |=> !fast_trickle_output_r) else $error("uvlo output high");
   a_temp_noexp: assert property (@(posedge clk) disable iff (!rst_n)
      !timer_en && state_r == CTT_FAST |=> state_r == CTT_FAST)
      else $error("disabled timer expired");
   a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
      tick_r |=> !tick_r) else $error("tick too dense");
endmodule : ctt_charge_timer

//--- ctt_front_model.sv
// comparator front end model that turns commanded pin levels into flags
`timescale 1ns/1ps
module ctt_front_model
   import ctt_pkg::*;
(
   input  wire logic          clk,
   input  wire logic [1:0]    sense_lvl,
   input  wire logic          neg_bias,
   input  wire logic          uvlo_cmd,
   input  wire logic          temp_cmd,
   input  wire logic [2:0]    tsel_cmd,
   output ctt_pkg::ctt_flags_t flags
);
   // sense level: 0 below window, 1 inside window, 2 above window
   always_ff @(posedge clk) begin
      flags.batt_low    <= (sense_lvl == 2'h0);
      flags.batt_window <= (sense_lvl == 2'h1);
      flags.tsel0_neg   <= neg_bias;
      flags.temp_bias   <= temp_cmd;
      flags.uvlo        <= uvlo_cmd;
      flags.tsel        <= tsel_cmd;
   end
endmodule : ctt_front_model

//--- ctt_charge_timer_bench.sv
// self-checking bench for the charge timer bypass switches
`timescale 1ns/1ps
module ctt_charge_timer_bench;
   import ctt_pkg::*;
   localparam int GT = 64;
   localparam int HT = 4096;
   localparam int DIV = 2;
   logic       clk;
   logic       rst_n;
   logic       neg_bias;
   logic       uvlo_cmd;
   logic       temp_cmd;
   logic [1:0] sense_lvl;
   logic [2:0] tsel_cmd;
   ctt_flags_t flags;
   logic       fast;
   logic       gate;
   logic       rpulse;
   logic       hold;
   int         n_mismatch = 0;
   int         compares = 0;

   ctt_front_model FE (.clk(clk), .sense_lvl(sense_lvl), .neg_bias(neg_bias),
      .uvlo_cmd(uvlo_cmd), .temp_cmd(temp_cmd), .tsel_cmd(tsel_cmd), .flags(flags));
   ctt_charge_timer #(.GATE_TICKS_P(GT), .HOLDOFF_TICKS_P(HT), .OSC_DIV_P(DIV)) DUT (
      .clk(clk),
      .rst_n(rst_n), .flags_in(flags), .fast_trickle_output_r(fast),
      .sense_sample_gate_output(gate), .timer_reset_pulse_r(rpulse), .holdoff_done(hold));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic finish_test();
      if (n_mismatch == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // edges from the sense change until the reset pulse, capped
   task automatic set_sense(input logic [1:0] v, output int n);
      @(posedge clk);
      sense_lvl <= v;
      n = 0;
      do begin
         step(1);
         n++;
      end while (rpulse !== 1'b1 && n < 20);
   endtask : set_sense

   task automatic enter_window();
      int n;
      set_sense(2'h2, n);
      set_sense(2'h1, n);
      chk(n >= 4 && n <= 6, "no reset pulse on window entry");
      step(1);
      chk(rpulse === 1'b0 && fast === 1'b1, "fast not entered");
   endtask : enter_window

   task automatic t_uvlo();
      int n;
      @(posedge clk);
      uvlo_cmd <= 1'b1;
      step(6);
      chk(fast === 1'b0, "fast kept in lockout");
      set_sense(2'h2, n);
      set_sense(2'h1, n);
      chk(fast === 1'b0 && n >= 4 && n <= 6, "lockout let fast through");
      @(posedge clk);
      uvlo_cmd <= 1'b0;
      step(6);
      chk(fast === 1'b1, "no fast after lockout");
   endtask : t_uvlo

   task automatic gate_per(output int p);
      int k;
      k = 0;
      while (gate !== 1'b1 && k < 3000) begin
         step(1);
         k++;
      end
      p = 0;
      do begin
         step(1);
         p++;
      end while (gate !== 1'b1 && p < 3000);
   endtask : gate_per

   task automatic t_gate(input logic nb, input int e);
      int p;
      @(posedge clk);
      neg_bias <= nb;
      gate_per(p);
      gate_per(p);
      chk(p >= e - DIV && p <= e + DIV, "gate period wrong");
   endtask : t_gate

   task automatic t_hold();
      int n;
      enter_window();
      chk(hold === 1'b0, "holdoff not cleared");
      n = 0;
      while (hold !== 1'b1 && n < 200) begin
         step(1);
         n++;
      end
      chk(n <= HT / 2048 * DIV + 8, "fast holdoff too slow");
      @(posedge clk);
      neg_bias <= 1'b0;
      step(4);
      enter_window();
      step(2000);
      chk(hold === 1'b0, "normal holdoff too quick");
   endtask : t_hold

   task automatic t_expiry();
      int n;
      int e;
      e = 2 * (1 << (LIMIT_LSB - SW1_SKIP)) * DIV;
      set_sense(2'h2, n);
      set_sense(2'h0, n);
      chk(n >= 4 && n <= 6, "no timer restart on low sense");
      step(e - e / 32);
      chk(fast === 1'b1, "test limit expired early");
      n = 0;
      while (fast !== 1'b0 && n < e / 16) begin
         step(1);
         n++;
      end
      chk(fast === 1'b0, "test limit never expired");
      step(100);
      chk(fast === 1'b0, "trickle not latched");
   endtask : t_expiry

   // temperature backup bias keeps the timer from ever expiring
   task automatic t_temp();
      int n;
      int e;
      e = 2 * (1 << (LIMIT_LSB - SW1_SKIP)) * DIV;
      @(posedge clk);
      temp_cmd <= 1'b1;
      set_sense(2'h2, n);
      set_sense(2'h0, n);
      chk(n >= 4 && n <= 6, "no restart with timer disabled");
      step(e + e / 16);
      chk(fast === 1'b1, "disabled timer expired");
      @(posedge clk);
      temp_cmd <= 1'b0;
   endtask : t_temp

   // low sense plus negative bit0 must run slower than switch one
   task automatic t_sw2();
      int n;
      int e;
      e = 2 * (1 << (LIMIT_LSB - SW1_SKIP)) * DIV;
      @(posedge clk);
      neg_bias <= 1'b1;
      set_sense(2'h2, n);
      set_sense(2'h0, n);
      chk(n >= 4 && n <= 6, "no restart in switch two");
      step(e + e / 16);
      chk(fast === 1'b1, "switch two not slower");
      @(posedge clk);
      neg_bias <= 1'b0;
   endtask : t_sw2

   initial begin
      repeat (80000) @(posedge clk);
      n_mismatch++;
      finish_test();
   end

   initial begin
      rst_n = 1'b0;
      sense_lvl = 2'h2;
      neg_bias = 1'b0;
      uvlo_cmd = 1'b0;
      temp_cmd = 1'b0;
      tsel_cmd = 3'h1;
      step(9);
      chk(fast === 1'b0 && rpulse === 1'b0 && hold === 1'b0, "outputs set in reset");
      @(posedge clk);
      rst_n <= 1'b1;
      step(4);
      enter_window();
      t_uvlo();
      t_gate(1'b0, GT * DIV);
      t_gate(1'b1, GT * DIV / 32);
      t_hold();
      t_temp();
      t_sw2();
      t_expiry();
      finish_test();
   end
endmodule : ctt_charge_timer_bench
